// file: hw/scs_pkg.sv
// Constants shared by the switch control serial port design
package scs_pkg;

   // ==========================================================
   // Clock and word layout
   localparam int unsigned CLK_MHZ    = 25;
   localparam int unsigned CLK_KHZ    = 25000;
   localparam int unsigned WORD_W     = 16;
   localparam int unsigned NOUT       = 12;
   localparam int unsigned NHS        = 4;
   localparam int unsigned NFS        = 2;
   localparam int unsigned WD_BIT     = 15;
   localparam int unsigned ADDR_HI    = 14;
   localparam int unsigned ADDR_MID   = 13;
   localparam int unsigned ADDR_LO    = 12;
   localparam int unsigned WD_DIV_LSB = 4;
   localparam int unsigned WD_DIV_MSB = 5;

   // ==========================================================
   // Command register addresses, first letter is bit 12
   localparam logic [2:0] ADDR_OUT_CTRL  = 3'h0;
   localparam logic [2:0] ADDR_DIRECT_EN = 3'h1;
   localparam logic [2:0] ADDR_LOGIC_FN  = 3'h2;
   localparam logic [2:0] ADDR_WD_SENSE  = 3'h3;
   localparam logic [2:0] ADDR_OPEN_LOAD = 3'h4;
   localparam logic [2:0] ADDR_LIMIT_OC  = 3'h5;
   localparam int unsigned NCFG          = 6;
   localparam logic [11:0] DIRECT_EN_RST = 12'hfff;
   localparam logic [11:0] CFG_RST       = 12'h000;

   // ==========================================================
   // Timing
   localparam int unsigned SW_DLY_NS   = 1000;
   localparam int unsigned SW_DLY_CYC  = (SW_DLY_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned FLT_DLY_US  = 150;
   localparam int unsigned FLT_DLY_CYC = FLT_DLY_US * CLK_MHZ;
   localparam int unsigned PEAK_MS     = 70;
   localparam int unsigned PEAK_CYC    = PEAK_MS * CLK_KHZ;
   localparam int unsigned WDTO_MS     = 524;
   localparam int unsigned WDTO_CYC    = WDTO_MS * CLK_KHZ;

   // ==========================================================
   // Bus register map
   localparam logic [11:0] REG_CTRL     = 12'h000;
   localparam logic [11:0] REG_STATUS   = 12'h004;
   localparam logic [11:0] REG_LAST_CMD = 12'h008;
   localparam logic [11:0] REG_DROP_CNT = 12'h00c;
   localparam int unsigned CTRL_EN_BIT  = 0;
   localparam logic        CTRL_EN_RST  = 1'h1;
   localparam int unsigned ST_WDEXP_BIT = 12;
   localparam int unsigned ST_PEAK_LSB  = 13;
   localparam int unsigned ST_LATCH_LSB = 17;

   // ==========================================================
   // Frame state
   typedef enum logic {SPI_IDLE, SPI_SHIFT} scs_spi_state_type;

endpackage

// file: hw/scs_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none

module scs_sync #(
   parameter int unsigned W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Clock and reset
   input  wire logic         clock,
   input  wire logic         arst_n,
   // Data
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);

   logic [W-1:0] meta_q;

   // ==========================================================
   // Per-bit two stage chain
   for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clock or negedge arst_n) begin
         if (!arst_n) begin
            meta_q[i] <= RST_VAL[i];
            dout[i]   <= RST_VAL[i];
         end else begin
            meta_q[i] <= din[i];
            dout[i]   <= meta_q[i];
         end
      end
   end

endmodule
`default_nettype wire

// file: hw/scs_top.sv
// Switch control serial port with APB status and control
// Summary of operation
// - Shift status out while command shifts in
// - Sample serial input on clock falling edge
// - Change serial output on clock rising edge
// - Sixteen bit words, most significant first
// - Idle select ignores clock, output disabled
// - Select rise writes word to addressed register
// - Select fall loads status into shifter
// - Command bit one turns output on
// - Status bits 0-11 flag faulted outputs
// - Bits 12-14 show inputs, chosen by watchdog bit
// - Three bit address plus twelve data bits
// - Outputs switch 1 us after select
// - Low-side overcurrent latch-off after fault delay
// - Watchdog timeout with failsafe input high turns first two high-sides on
// - Peak limit active for timer after select
// - Data bits 0-11, address 12-14, watchdog 15
// - Drop frames not a multiple of sixteen
// - Two bit field divides watchdog timeout
`timescale 1ns/1ps
`default_nettype none

module scs_top
   import scs_pkg::*;
#(
   parameter int unsigned PEAK_CYCLES = PEAK_CYC,
   parameter int unsigned WDTO_CYCLES = WDTO_CYC
) (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        arst_n,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Serial link
   input  wire logic        select_n,
   input  wire logic        sclk,
   input  wire logic        sdi,
   output logic             sdo,
   output logic             sdo_oe,
   // Device pins and analog status
   input  wire logic        reset_in_n,
   input  wire logic        failsafe_input,
   input  wire logic [3:0]  direct_hs,
   input  wire logic        direct_ls,
   input  wire logic [5:0]  input_states,
   input  wire logic [11:0] fault_in,
   input  wire logic [11:4] overcurrent_in,
   // Output drive
   output logic      [11:0] out_on,
   output logic      [3:0]  peak_limit,
   output logic             wd_expired
);

   // ==========================================================
   // Input synchronisers
   localparam int unsigned SYNC_W = 36;
   localparam logic [SYNC_W-1:0] SYNC_RST = {1'b1, 2'b00, 1'b1, 32'h0};

   logic [SYNC_W-1:0] sync_out;
   logic              sel_s, sclk_s, sdi_s, rstin_s, fs_s, ils_s;
   logic [3:0]        ihs_s;
   logic [5:0]        ins_s;
   logic [11:0]       flt_s;
   logic [11:4]       oc_s;

   scs_sync #(.W(SYNC_W), .RST_VAL(SYNC_RST)) u_sync (
      .clock  (clock),
      .arst_n (arst_n),
      .din    ({select_n, sclk, sdi, reset_in_n, failsafe_input, direct_ls,
                direct_hs, input_states, fault_in, overcurrent_in}),
      .dout   (sync_out)
   );

   assign {sel_s, sclk_s, sdi_s, rstin_s, fs_s, ils_s, ihs_s, ins_s, flt_s, oc_s} = sync_out;

   // ==========================================================
   // Edge detection
   scs_spi_state_type state_q, state_d;
   logic sel_d_q, sclk_d_q;
   logic sel_fall, sel_rise, sclk_rise, sclk_fall, soft_rst;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         sel_d_q  <= 1'b1;
         sclk_d_q <= 1'b0;
      end else begin
         sel_d_q  <= sel_s;
         sclk_d_q <= sclk_s;
      end
   end

   assign soft_rst  = ~rstin_s;
   assign sel_fall  = sel_d_q & ~sel_s;
   assign sel_rise  = ~sel_d_q & sel_s;
   // Clock ignored unless a frame is open
   assign sclk_rise = (state_q == SPI_SHIFT) & ~sel_s & ~sclk_d_q & sclk_s;
   assign sclk_fall = (state_q == SPI_SHIFT) & ~sel_s & sclk_d_q & ~sclk_s;

   always_comb begin
      state_d = state_q;
      case (state_q)
         SPI_IDLE:  if (sel_fall) state_d = SPI_SHIFT;
         SPI_SHIFT: if (sel_rise) state_d = SPI_IDLE;
         default:   state_d = SPI_IDLE;
      endcase
   end

   // ==========================================================
   // Shift registers
   logic [15:0] rx_q, tx_q, status_word;
   logic [3:0]  bit_cnt_q;
   logic        any_bit_q, sdo_q, sdo_oe_q, port_en_q;
   logic        frame_ok, commit, drop;
   logic [2:0]  cmd_addr;
   logic [11:0] cmd_data;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state_q   <= SPI_IDLE;
         rx_q      <= 16'h0000;
         tx_q      <= 16'h0000;
         bit_cnt_q <= 4'h0;
         any_bit_q <= 1'b0;
         sdo_q     <= 1'b0;
         sdo_oe_q  <= 1'b0;
      end else begin
         state_q  <= state_d;
         sdo_oe_q <= ~sel_s;
         if (sel_fall) begin
            tx_q      <= status_word;
            sdo_q     <= status_word[15];
            bit_cnt_q <= 4'h0;
            any_bit_q <= 1'b0;
         end else begin
            if (sclk_rise) begin
               sdo_q <= tx_q[15];
               tx_q  <= {tx_q[14:0], 1'b0};
            end
            if (sclk_fall) begin
               rx_q      <= {rx_q[14:0], sdi_s};
               bit_cnt_q <= bit_cnt_q + 4'h1;
               any_bit_q <= 1'b1;
            end
         end
      end
   end

   // Whole multiples of sixteen only; later words replace earlier ones
   assign frame_ok = (state_q == SPI_SHIFT) & sel_rise & any_bit_q
                     & (bit_cnt_q == 4'h0);
   assign commit   = frame_ok & port_en_q & ~soft_rst;
   assign drop     = (state_q == SPI_SHIFT) & sel_rise & ~frame_ok;
   assign cmd_addr = {rx_q[ADDR_LO], rx_q[ADDR_MID], rx_q[ADDR_HI]};
   assign cmd_data = rx_q[NOUT-1:0];

   // ==========================================================
   // Command registers
   logic [11:0] cfg_q [NCFG];
   logic        wd_bit_q;
   logic        wd_kick;

   for (genvar a = 0; a < NCFG; a++) begin : g_cfg
      localparam logic [2:0] A = 3'(a);
      always_ff @(posedge clock or negedge arst_n) begin
         if (!arst_n) begin
            cfg_q[a] <= (A == ADDR_DIRECT_EN) ? DIRECT_EN_RST : CFG_RST;
         end else if (soft_rst) begin
            cfg_q[a] <= (A == ADDR_DIRECT_EN) ? DIRECT_EN_RST : CFG_RST;
         end else if (commit && cmd_addr == A) begin
            cfg_q[a] <= cmd_data;
         end
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         wd_bit_q <= 1'b0;
      end else if (soft_rst) begin
         wd_bit_q <= 1'b0;
      end else if (commit) begin
         wd_bit_q <= rx_q[WD_BIT];
      end
   end

   assign wd_kick = commit & (rx_q[WD_BIT] ^ wd_bit_q);

   // ==========================================================
   // Output control
   logic [11:0] target, latched_q, latch_set, latch_clr, out_q;
   logic [4:0]  sw_cnt_q;
   logic        wd_exp_q;

   for (genvar i = 0; i < NOUT; i++) begin : g_out
      logic din_i, comb_i, force_i;
      assign din_i   = (i < NHS) ? ihs_s[i % NHS] : ils_s;
      // Direct input enabled when its bit is low; AND or OR with command
      assign comb_i  = cfg_q[ADDR_DIRECT_EN][i] ? cfg_q[ADDR_OUT_CTRL][i] :
                       (cfg_q[ADDR_LOGIC_FN][i] ? (cfg_q[ADDR_OUT_CTRL][i] & din_i)
                                                : (cfg_q[ADDR_OUT_CTRL][i] | din_i));
      assign force_i = (i < NFS) & wd_exp_q & fs_s;
      assign target[i] = (comb_i | force_i) & ~latched_q[i];
   end

   // Hold old state for the switching delay after each command
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         sw_cnt_q <= 5'h0;
         out_q    <= 12'h000;
      end else if (commit) begin
         sw_cnt_q <= 5'(SW_DLY_CYC - 1);
      end else if (sw_cnt_q != 5'h0) begin
         sw_cnt_q <= sw_cnt_q - 5'h1;
      end else begin
         out_q <= target;
      end
   end

   // ==========================================================
   // Low-side fault latch-off timer
   logic [11:0] flt_cnt_q;
   logic        flt_run_q, flt_done;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         flt_cnt_q <= 12'h000;
         flt_run_q <= 1'b0;
      end else if (commit) begin
         flt_cnt_q <= 12'(FLT_DLY_CYC - 1);
         flt_run_q <= 1'b1;
      end else if (flt_run_q) begin
         flt_cnt_q <= flt_cnt_q - 12'h001;
         flt_run_q <= (flt_cnt_q != 12'h000);
      end
   end

   assign flt_done  = flt_run_q & (flt_cnt_q == 12'h000);
   assign latch_set = flt_done ? ({oc_s, 4'h0} & cfg_q[ADDR_LIMIT_OC] & {8'hff, 4'h0}) : 12'h000;
   assign latch_clr = (commit && cmd_addr == ADDR_OUT_CTRL) ? 12'hfff : 12'h000;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         latched_q <= 12'h000;
      end else if (soft_rst) begin
         latched_q <= 12'h000;
      end else begin
         latched_q <= (latched_q & ~latch_clr) | latch_set;
      end
   end

   // ==========================================================
   // Peak current limit timer
   logic [20:0] peak_cnt_q;
   logic        peak_run_q;
   logic [3:0]  peak_q;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         peak_cnt_q <= 21'h0;
         peak_run_q <= 1'b0;
         peak_q     <= 4'h0;
      end else begin
         if (commit) begin
            peak_cnt_q <= 21'(PEAK_CYCLES - 1);
            peak_run_q <= 1'b1;
         end else if (peak_run_q) begin
            peak_cnt_q <= peak_cnt_q - 21'h1;
            peak_run_q <= (peak_cnt_q != 21'h0);
         end
         peak_q <= {4{peak_run_q}} & ~cfg_q[ADDR_LIMIT_OC][NHS-1:0];
      end
   end

   // ==========================================================
   // Watchdog
   logic [23:0] wd_cnt_q, wd_lim;

   assign wd_lim = 24'(WDTO_CYCLES) >> cfg_q[ADDR_WD_SENSE][WD_DIV_MSB:WD_DIV_LSB];

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         wd_cnt_q <= 24'h0;
         wd_exp_q <= 1'b0;
      end else if (soft_rst || wd_kick) begin
         wd_cnt_q <= 24'h0;
         wd_exp_q <= 1'b0;
      end else if (!wd_exp_q) begin
         wd_cnt_q <= wd_cnt_q + 24'h1;
         wd_exp_q <= (wd_cnt_q >= wd_lim - 24'h1);
      end
   end

   // ==========================================================
   // Status word
   assign status_word = {wd_bit_q,
                         wd_bit_q ? ins_s[5:3] : ins_s[2:0],
                         flt_s | latched_q};

   // ==========================================================
   // APB slave, one wait-free access phase
   logic [15:0] last_cmd_q, drop_cnt_q;
   logic [31:0] rd_mux, prdata_q;
   logic        pready_q, pslverr_q, setup, wr_en, hit;

   assign setup = psel & ~penable;
   assign wr_en = psel & penable & pready_q & pwrite;
   assign hit   = (paddr == REG_CTRL) | (paddr == REG_STATUS)
                | (paddr == REG_LAST_CMD) | (paddr == REG_DROP_CNT);
   assign rd_mux = (paddr == REG_CTRL)     ? {31'h0, port_en_q} :
                   (paddr == REG_STATUS)   ? {3'h0, latched_q, peak_q, wd_exp_q, out_q} :
                   (paddr == REG_LAST_CMD) ? {16'h0, last_cmd_q} :
                   (paddr == REG_DROP_CNT) ? {16'h0, drop_cnt_q} : 32'h0;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         pready_q   <= 1'b0;
         pslverr_q  <= 1'b0;
         prdata_q   <= 32'h0;
         port_en_q  <= CTRL_EN_RST;
         last_cmd_q <= 16'h0;
         drop_cnt_q <= 16'h0;
      end else begin
         pready_q  <= setup;
         pslverr_q <= setup & ~hit;
         prdata_q  <= setup ? rd_mux : 32'h0;
         if (wr_en && paddr == REG_CTRL) begin
            port_en_q <= pwdata[CTRL_EN_BIT];
         end
         if (commit) begin
            last_cmd_q <= rx_q;
         end
         if (drop || (frame_ok && !commit)) begin
            drop_cnt_q <= drop_cnt_q + 16'h1;
         end
      end
   end

   // ==========================================================
   // Output registers
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         out_on     <= 12'h000;
         peak_limit <= 4'h0;
         wd_expired <= 1'b0;
      end else begin
         out_on     <= out_q;
         peak_limit <= peak_q;
         wd_expired <= wd_exp_q;
      end
   end

   assign prdata  = prdata_q;
   assign pready  = pready_q;
   assign pslverr = pslverr_q;
   assign sdo     = sdo_q;
   assign sdo_oe  = sdo_oe_q;

endmodule
`default_nettype wire

// file: test/scs_spi_master.sv
// Serial bus master model for the switch control serial port
`timescale 1ns/1ps
`default_nettype none

module scs_spi_master (
   // Clock
   input  wire logic clock,
   // Serial link
   output logic      select_n,
   output logic      sclk,
   output logic      sdi,
   input  wire logic sdo,
   input  wire logic sdo_oe
);
   // ==========================================
   // Idle lines: deselected, clock low, data pulled low
   initial begin
      select_n = 1'b1;
      sclk     = 1'b0;
      sdi      = 1'b0;
   end

   // ==========================================
   // One frame of n bits, top bit of tx first, eight clocks a bit
   task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
      rx = 32'h0;
      @(posedge clock);
      select_n <= 1'b0;
      repeat (8) @(posedge clock);
      for (int i = n - 1; i >= 0; i--) begin
         sdi <= tx[i];
         @(posedge clock);
         sclk <= 1'b1;
         repeat (4) @(posedge clock);
         rx[i] = sdo_oe ? sdo : 1'bx;
         sclk  <= 1'b0;
         repeat (3) @(posedge clock);
      end
      repeat (2) @(posedge clock);
      select_n <= 1'b1;
      sdi      <= 1'b0;
      repeat (5) @(posedge clock);
   endtask
endmodule

`default_nettype wire

// file: test/scs_top_sva.sv
// Assertion checker for the switch control serial port
`timescale 1ns/1ps
`default_nettype none

module scs_top_sva
   import scs_pkg::*;
#(
   parameter int unsigned PEAK_CYCLES = PEAK_CYC,
   parameter int unsigned WDTO_CYCLES = WDTO_CYC
) (
   // Clock, reset and register bus
   input wire logic        clock,
   input wire logic        arst_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [11:0] paddr,
   input wire logic        pready,
   input wire logic        pslverr,
   // Serial link
   input wire logic        select_n,
   input wire logic        sclk,
   input wire logic        sdo,
   input wire logic        sdo_oe,
   // Pins and drive
   input wire logic        reset_in_n,
   input wire logic        failsafe_input,
   input wire logic [11:0] out_on,
   input wire logic [3:0]  peak_limit,
   input wire logic        wd_expired
);
   // ==========================================
   // Length of the current peak limit pulse
   logic [31:0] hi_q;
   logic [31:0] hi_d;
   assign hi_d = peak_limit[0] ? hi_q + 32'h1 : 32'h0;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         hi_q <= 32'h0;
      end else begin
         hi_q <= hi_d;
      end
   end

   // ==========================================
   // Properties
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);
   property p_oe_off; select_n [*6] |-> !sdo_oe; endproperty
   a_oe_off: assert property (p_oe_off) else $error("sdo driven while deselected");
   property p_oe_on; !select_n [*6] |-> sdo_oe; endproperty
   a_oe_on: assert property (p_oe_on) else $error("sdo not driven while selected");
   property p_sdo_hold; (!sclk && !select_n) [*7] |-> $stable(sdo); endproperty
   a_sdo_hold: assert property (p_sdo_hold) else $error("sdo moved without clock rise");
   property p_sw_min; $rose(select_n) |=> $stable(out_on) [*8]; endproperty
   a_sw_min: assert property (p_sw_min) else $error("outputs switched too early");
   property p_wd_on; wd_expired && failsafe_input |-> ##[0:40] out_on[1:0] == 2'b11; endproperty
   a_wd_on: assert property (p_wd_on) else $error("fail-safe outputs not on");
   property p_rst_wd; !reset_in_n [*5] |-> !wd_expired; endproperty
   a_rst_wd: assert property (p_rst_wd) else $error("watchdog not cleared by reset pin");
   property p_peak;
      $fell(peak_limit[0]) && reset_in_n |-> hi_q >= PEAK_CYCLES - 30 && hi_q <= PEAK_CYCLES + 4;
   endproperty
   a_peak: assert property (p_peak) else $error("peak limit pulse length wrong");
   property p_rdy; psel && !penable |=> pready; endproperty
   a_rdy: assert property (p_rdy) else $error("bus answer missing");
   property p_err; pready && paddr > 12'h00c |-> pslverr; endproperty
   a_err: assert property (p_err) else $error("unmapped access without error");
   c_frame: cover property ($rose(select_n));
   c_wd: cover property ($rose(wd_expired) && failsafe_input);
   c_err: cover property (pready && pslverr);
endmodule

bind scs_top scs_top_sva #(.PEAK_CYCLES(PEAK_CYCLES), .WDTO_CYCLES(WDTO_CYCLES))
   i_sva (.*);

`default_nettype wire

// file: test/tb.sv
// Testbench for the switch control serial port
`timescale 1ns/1ps
`default_nettype none

module tb;
   import scs_pkg::*;
   localparam int unsigned PKC = 60;
   localparam int unsigned WDC = 400;
   // ==========================================
   // Signals
   logic        clock = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        reset_in_n = 1'b1, failsafe_input = 1'b0, direct_ls = 1'b0;
   logic [3:0]  direct_hs = 4'h0;
   logic [11:0] paddr = 12'h000, fault_in = 12'ha4c;
   logic [31:0] pwdata = 32'h0;
   logic [5:0]  input_states = 6'h2b;
   logic [11:4] overcurrent_in = 8'h00;
   logic        pready, pslverr, select_n, sclk, sdi, sdo, sdo_oe, wd_expired, er;
   logic [31:0] prdata, rx, rd;
   logic [11:0] out_on;
   logic [3:0]  peak_limit;
   int          error_cnt = 0, comparisons = 0;

   scs_top #(.PEAK_CYCLES(PKC), .WDTO_CYCLES(WDC)) i_dut (.*);
   scs_spi_master i_mst (.clock(clock), .select_n(select_n), .sclk(sclk), .sdi(sdi), .sdo(sdo),
                         .sdo_oe(sdo_oe));

   always #20 clock = ~clock;

   // ==========================================
   // Helpers
   task automatic chk(input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: expected %h, got %h", $time, exp, got);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clock);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) error_cnt++;
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   function automatic logic [15:0] cmd(input logic w, input logic [2:0] a, input logic [11:0] d);
      return {w, a[0], a[1], a[2], d};
   endfunction

   function automatic logic [15:0] st(input logic w);
      return {w, w ? input_states[5:3] : input_states[2:0], fault_in};
   endfunction

   // ==========================================
   // Scenarios
   task automatic t_regs;
      apb(1'b0, REG_CTRL, 32'h0);
      chk(32'h1, rd);
      apb(1'b1, REG_LAST_CMD, 32'hffff);
      chk(32'h0, {31'h0, er});
      apb(1'b0, REG_LAST_CMD, 32'h0);
      chk(32'h0, rd);
      apb(1'b0, 12'h010, 32'h0);
      chk(32'h1, {31'h0, er});
      chk(32'h0, rd);
      $display("register test done");
   endtask

   task automatic t_frame;
      i_mst.xfer(16, {16'h0, cmd(1'b1, ADDR_OUT_CTRL, 12'h813)}, rx);
      chk({16'h0, st(1'b0)}, rx);
      repeat (40) @(posedge clock);
      chk(32'h813, {20'h0, out_on});
      apb(1'b0, REG_LAST_CMD, 32'h0);
      chk({16'h0, cmd(1'b1, ADDR_OUT_CTRL, 12'h813)}, rd);
      i_mst.xfer(32, {cmd(1'b1, ADDR_OUT_CTRL, 12'h0f0), cmd(1'b0, ADDR_OUT_CTRL, 12'h00c)}, rx);
      chk({st(1'b1), 16'h0}, rx);
      repeat (40) @(posedge clock);
      chk(32'h00c, {20'h0, out_on});
      $display("frame test done");
   endtask

   task automatic t_drop;
      logic [31:0] d0;
      apb(1'b0, REG_DROP_CNT, 32'h0);
      d0 = rd;
      i_mst.xfer(12, 32'hfff, rx);
      i_mst.xfer(0, 32'h0, rx);
      apb(1'b1, REG_CTRL, 32'h0);
      apb(1'b0, REG_CTRL, 32'h0);
      chk(32'h0, rd);
      i_mst.xfer(16, {16'h0, cmd(1'b1, ADDR_OUT_CTRL, 12'hfff)}, rx);
      repeat (40) @(posedge clock);
      chk(32'h00c, {20'h0, out_on});
      apb(1'b1, REG_CTRL, 32'h1);
      apb(1'b0, REG_DROP_CNT, 32'h0);
      chk(d0 + 32'h3, rd);
      $display("drop test done");
   endtask

   task automatic t_latch;
      overcurrent_in <= 8'h01;
      i_mst.xfer(16, {16'h0, cmd(1'b0, ADDR_LIMIT_OC, 12'h010)}, rx);
      i_mst.xfer(16, {16'h0, cmd(1'b1, ADDR_OUT_CTRL, 12'h010)}, rx);
      repeat (1700) @(posedge clock);
      chk(32'h1, {31'h0, out_on[4]});
      repeat (4600) @(posedge clock);
      chk(32'h0, {31'h0, out_on[4]});
      overcurrent_in <= 8'h00;
      i_mst.xfer(16, {16'h0, cmd(1'b0, ADDR_OUT_CTRL, 12'h010)}, rx);
      chk({16'h0, st(1'b1) | 16'h0010}, rx);
      repeat (40) @(posedge clock);
      chk(32'h1, {31'h0, out_on[4]});
      $display("latch-off test done");
   endtask

   task automatic t_peak;
      i_mst.xfer(16, {16'h0, cmd(1'b1, ADDR_OUT_CTRL, 12'h001)}, rx);
      repeat (40) @(posedge clock);
      chk(32'h1, {31'h0, peak_limit[0]});
      apb(1'b0, REG_STATUS, 32'h0);
      chk({3'h0, 12'h000, 4'hf, 1'b0, 12'h001}, rd);
      repeat (40) @(posedge clock);
      chk(32'h0, {31'h0, peak_limit[0]});
      direct_hs <= 4'h4;
      i_mst.xfer(16, {16'h0, cmd(1'b1, ADDR_DIRECT_EN, 12'hffb)}, rx);
      repeat (40) @(posedge clock);
      chk(32'h005, {20'h0, out_on});
      i_mst.xfer(16, {16'h0, cmd(1'b1, ADDR_LOGIC_FN, 12'h004)}, rx);
      repeat (40) @(posedge clock);
      chk(32'h001, {20'h0, out_on});
      $display("peak limit test done");
   endtask

   task automatic t_wd;
      i_mst.xfer(16, {16'h0, cmd(1'b0, ADDR_WD_SENSE, 12'h030)}, rx);
      repeat (3) @(posedge clock);
      failsafe_input <= 1'b1;
      repeat (30) @(posedge clock);
      chk(32'h0, {31'h0, wd_expired});
      repeat (30) @(posedge clock);
      chk(32'h1, {31'h0, wd_expired});
      repeat (40) @(posedge clock);
      chk(32'h3, {30'h0, out_on[1:0]});
      failsafe_input <= 1'b0;
      reset_in_n     <= 1'b0;
      repeat (6) @(posedge clock);
      reset_in_n <= 1'b1;
      repeat (4) @(posedge clock);
      chk(32'h0, {31'h0, wd_expired});
      $display("watchdog test done");
   endtask

   // ==========================================
   // Run control
   task automatic complete_run;
      $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial begin
      #800000;
      error_cnt++;
      $display("watchdog expired at %0t", $time);
      complete_run();
   end

   initial begin
      repeat (16) @(posedge clock);
      arst_n <= 1'b1;
      repeat (4) @(posedge clock);
      t_regs();
      t_frame();
      t_drop();
      t_latch();
      t_peak();
      t_wd();
      complete_run();
   end
endmodule

`default_nettype wire
